// ===== logic/wit_consts.svh
// Summary of operation
// RQ1 - Overflow flag sets when the eight-bit count wraps from FF to 00.
// RQ2 - Overflow flag clears by reading it as one, then writing zero; one ignored.
// RQ3 - Watchdog-reset flag sets when an overflow raises the internal reset.
// RQ4 - External reset pin clears the watchdog-reset flag.
// RQ5 - Watchdog-reset flag clears by reading it as one, then writing zero.
// RQ6 - In reset cause register only bit 7 is clear-only; written one ignored.
// RQ7 - Reset cause register reads at one index and writes at the adjacent one.
// RQ8 - Disabled holds count at zero; enabled counts prescaled; overflow interrupts or resets.
`ifndef WIT_CONSTS_SVH
`define WIT_CONSTS_SVH

// Register indices; byte address is four times the index
`define WIT_IDX_TIMER_CONTROL_STATUS        10'h00A7
`define WIT_IDX_COUNT_RD    10'h00A9
`define WIT_IDX_COUNT_WR    10'h00A8
`define WIT_IDX_RCC_RD      10'h00AB
`define WIT_IDX_RCC_WR      10'h00AA
`define WIT_IDX_IRQ_STAT    10'h00AC
`define WIT_IDX_IRQ_MASK    10'h00AD

// Field positions
`define WIT_TIMER_CONTROL_STATUS_OVF        7
`define WIT_TIMER_CONTROL_STATUS_MODE       6
`define WIT_TIMER_CONTROL_STATUS_RUN        5
`define WIT_RCC_FLAG        7
`define WIT_RCC_OE          6
`define WIT_IRQ_INTERVAL    0
`define WIT_IRQ_WDRESET     1

// Reset values and reserved read-back
`define WIT_COUNT_RESET     8'h00
`define WIT_COUNT_MAX       8'hFF
`define WIT_TIMER_CONTROL_STATUS_RSVD       8'h18
`define WIT_RCC_RSVD        8'h3F

// AXI responses
`define WIT_RESP_OKAY       2'h0
`define WIT_RESP_SLVERR     2'h2

// Prescaler divider taps, as log2 of the division
`define WIT_PRE_BITS        12
`define WIT_PRE_SH0         4'h1
`define WIT_PRE_SH1         4'h5
`define WIT_PRE_SH2         4'h6
`define WIT_PRE_SH3         4'h7
`define WIT_PRE_SH4         4'h8
`define WIT_PRE_SH5         4'h9
`define WIT_PRE_SH6         4'hB
`define WIT_PRE_SH7         4'hC

// Internal reset pulse: time in ns, then cycles at the clock rate (rounded up)
`define WIT_CLK_MHZ         20
`define WIT_RST_PULSE_NS    800
`define WIT_RST_PULSE_CYC   ((`WIT_RST_PULSE_NS * `WIT_CLK_MHZ + 999) / 1000)

`endif

// ===== logic/wit_pkg.sv
package wit_pkg;

   // Timer mode encoding
   typedef enum logic
   {
      WIT_MODE_INTERVAL = 1'b0,
      WIT_MODE_WATCHDOG = 1'b1
   } wit_mode_t;

   // Timer control/status fields
   typedef struct packed
   {
      logic        overflow_flag;
      wit_mode_t   timer_mode_select;
      logic        timer_run_bit;
      logic [2:0]  prescale_select;
   } wit_timer_control_status_t;

   // Reset cause/control fields
   typedef struct packed
   {
      logic        watchdog_reset_flag;
      logic        reset_output_enable;
   } wit_rcc_t;

endpackage

// ===== logic/wit_timer.sv
`timescale 1ns/10ps
`include "wit_consts.svh"

module wit_timer
(
   // Clock and external reset pin
   input  wire logic        MCLK_I,
   input  wire logic        RESETN_I,
   // AXI4-Lite write address
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [11:0] AWADDR_I,
   input  wire logic [2:0]  AWPROT_I,
   // AXI4-Lite write data
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   // AXI4-Lite write response
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   output logic [1:0]       BRESP_O,
   // AXI4-Lite read address
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   input  wire logic [11:0] ARADDR_I,
   input  wire logic [2:0]  ARPROT_I,
   // AXI4-Lite read data
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   // Interrupt and reset outputs
   output logic             IRQ_O,
   output logic             WDT_RESET_O,
   output logic             RESET_PIN_O,
   output logic             RESET_PIN_OE_O
);

   // Register state
   wit_pkg::wit_timer_control_status_t      timer_control_status_q;
   wit_pkg::wit_rcc_t       rcc_q;
   logic [7:0]              count_q;
   logic [`WIT_PRE_BITS-1:0] pre_q;
   logic [1:0]              irq_stat_q;
   logic [1:0]              irq_mask_q;
   logic                    ovf_armed_q;
   logic                    watchdog_reset_flag_armed_q;
   logic [9:0]              rst_cnt_q;
   logic                    rst_act_q;

   // Bus state
   logic                    awready_q;
   logic                    wready_q;
   logic                    aw_have_q;
   logic                    w_have_q;
   logic [9:0]              aw_idx_q;
   logic [7:0]              wdata_q;
   logic                    wlane_q;
   logic                    bvalid_q;
   logic [1:0]              bresp_q;
   logic                    arready_q;
   logic                    rvalid_q;
   logic [31:0]             rdata_q;
   logic [1:0]              rresp_q;
   logic                    irq_q;

   // Decoded events
   logic                    wr_fire;
   logic                    rd_fire;
   logic [9:0]              ar_idx;
   logic                    wr_timer_control_status;
   logic                    wr_count;
   logic                    wr_rcc;
   logic                    wr_stat;
   logic                    wr_mask;
   logic                    rd_timer_control_status;
   logic                    rd_rcc;
   logic                    tick;
   logic                    overflow;
   logic                    wd_trip;
   logic [3:0]              pre_sh;
   logic [`WIT_PRE_BITS-1:0] pre_mask;

   assign wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
   assign rd_fire  = ARVALID_I & arready_q;
   assign ar_idx   = ARADDR_I[11:2];
   // A write touches the register only when the low byte lane is enabled
   assign wr_timer_control_status  = wr_fire & wlane_q & (aw_idx_q == `WIT_IDX_TIMER_CONTROL_STATUS);
   assign wr_count = wr_fire & wlane_q & (aw_idx_q == `WIT_IDX_COUNT_WR);
   assign wr_rcc   = wr_fire & wlane_q & (aw_idx_q == `WIT_IDX_RCC_WR); // RQ7
   assign wr_stat  = wr_fire & wlane_q & (aw_idx_q == `WIT_IDX_IRQ_STAT);
   assign wr_mask  = wr_fire & wlane_q & (aw_idx_q == `WIT_IDX_IRQ_MASK);
   assign rd_timer_control_status  = rd_fire & (ar_idx == `WIT_IDX_TIMER_CONTROL_STATUS);
   assign rd_rcc   = rd_fire & (ar_idx == `WIT_IDX_RCC_RD); // RQ7

   // Prescale tap for the selected division
   always_comb
   begin
      case (timer_control_status_q.prescale_select)
         3'h0:    pre_sh = `WIT_PRE_SH0;
         3'h1:    pre_sh = `WIT_PRE_SH1;
         3'h2:    pre_sh = `WIT_PRE_SH2;
         3'h3:    pre_sh = `WIT_PRE_SH3;
         3'h4:    pre_sh = `WIT_PRE_SH4;
         3'h5:    pre_sh = `WIT_PRE_SH5;
         3'h6:    pre_sh = `WIT_PRE_SH6;
         default: pre_sh = `WIT_PRE_SH7;
      endcase
   end

   // Tick when the low pre_sh divider bits are all one: one pulse per period
   assign pre_mask = ~({`WIT_PRE_BITS{1'b1}} << pre_sh);
   assign tick     = timer_control_status_q.timer_run_bit & ((pre_q & pre_mask) == pre_mask); // RQ8
   assign overflow = tick & (count_q == `WIT_COUNT_MAX) & ~wr_count; // RQ1
   assign wd_trip  = overflow & (timer_control_status_q.timer_mode_select == wit_pkg::WIT_MODE_WATCHDOG);

   // Free-running divider; restarting it would skew the first period after enable
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         pre_q <= '0;
      else
         pre_q <= pre_q + 1'b1;
   end

   // Counter: a bus write wins over the increment
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         count_q <= `WIT_COUNT_RESET;
      else if (rst_act_q || !timer_control_status_q.timer_run_bit)
         count_q <= `WIT_COUNT_RESET; // RQ8
      else if (wr_count)
         count_q <= wdata_q;
      else if (tick)
         count_q <= count_q + 1'b1; // RQ8
   end

   // Timer control/status in one process so the struct has a single driver;
   // the internal reset returns it to its initial state and ignores writes.
   // Overflow flag: set wins, clear needs a prior read of one and a written zero
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         timer_control_status_q.overflow_flag     <= 1'b0;
         timer_control_status_q.timer_mode_select <= wit_pkg::WIT_MODE_INTERVAL;
         timer_control_status_q.timer_run_bit     <= 1'b0;
         timer_control_status_q.prescale_select   <= 3'h0;
         ovf_armed_q              <= 1'b0;
      end
      else if (rst_act_q)
      begin
         timer_control_status_q.overflow_flag     <= 1'b0;
         timer_control_status_q.timer_mode_select <= wit_pkg::WIT_MODE_INTERVAL;
         timer_control_status_q.timer_run_bit     <= 1'b0;
         timer_control_status_q.prescale_select   <= 3'h0;
         ovf_armed_q              <= 1'b0;
      end
      else
      begin
         if (rd_timer_control_status && timer_control_status_q.overflow_flag)
            ovf_armed_q <= 1'b1; // RQ2
         if (wr_timer_control_status)
         begin
            timer_control_status_q.timer_mode_select <= wit_pkg::wit_mode_t'(wdata_q[`WIT_TIMER_CONTROL_STATUS_MODE]);
            timer_control_status_q.timer_run_bit     <= wdata_q[`WIT_TIMER_CONTROL_STATUS_RUN];
            timer_control_status_q.prescale_select   <= wdata_q[2:0];
            ovf_armed_q              <= 1'b0;
            if (ovf_armed_q && !wdata_q[`WIT_TIMER_CONTROL_STATUS_OVF])
               timer_control_status_q.overflow_flag <= 1'b0; // RQ2
         end
         if (overflow)
            timer_control_status_q.overflow_flag <= 1'b1; // RQ1
      end
   end

   // Reset cause flag survives the internal reset; the pin or a read of one then written zero clears it.
   // The output enable beside it is plain read/write; one process, one driver.
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         rcc_q.watchdog_reset_flag <= 1'b0; // RQ4
         rcc_q.reset_output_enable <= 1'b0;
         watchdog_reset_flag_armed_q              <= 1'b0;
      end
      else
      begin
         if (rd_rcc && rcc_q.watchdog_reset_flag)
            watchdog_reset_flag_armed_q <= 1'b1; // RQ5
         if (wr_rcc)
         begin
            rcc_q.reset_output_enable <= wdata_q[`WIT_RCC_OE]; // RQ6
            watchdog_reset_flag_armed_q              <= 1'b0;
            if (watchdog_reset_flag_armed_q && !wdata_q[`WIT_RCC_FLAG])
               rcc_q.watchdog_reset_flag <= 1'b0; // RQ5 RQ6
         end
         // Set wins over a clear in the same cycle
         if (wd_trip)
            rcc_q.watchdog_reset_flag <= 1'b1; // RQ3
      end
   end

   // Internal reset pulse of fixed length after a watchdog overflow
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         rst_cnt_q <= 10'h000;
         rst_act_q <= 1'b0;
      end
      else if (wd_trip)
      begin
         rst_cnt_q <= 10'(`WIT_RST_PULSE_CYC - 1);
         rst_act_q <= 1'b1; // RQ8
      end
      else if (rst_cnt_q != 10'h000)
         rst_cnt_q <= rst_cnt_q - 1'b1;
      else
         rst_act_q <= 1'b0;
   end

   // Reset outputs; the pin is driven low only while enabled
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         WDT_RESET_O    <= 1'b0;
         RESET_PIN_O    <= 1'b0;
         RESET_PIN_OE_O <= 1'b0;
      end
      else
      begin
         WDT_RESET_O    <= rst_act_q;
         RESET_PIN_O    <= 1'b0;
         RESET_PIN_OE_O <= rst_act_q & rcc_q.reset_output_enable;
      end
   end

   // Sticky interrupt status, write one to clear, set wins over clear
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
         irq_stat_q <= 2'h0;
      else
      begin
         if (wr_stat)
            irq_stat_q <= irq_stat_q & ~wdata_q[1:0];
         if (overflow && !wd_trip)
            irq_stat_q[`WIT_IRQ_INTERVAL] <= 1'b1; // RQ8
         if (wd_trip)
            irq_stat_q[`WIT_IRQ_WDRESET] <= 1'b1;
      end
   end

   // Interrupt mask and level output
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         irq_mask_q <= 2'h0;
         irq_q      <= 1'b0;
      end
      else
      begin
         if (wr_mask)
            irq_mask_q <= wdata_q[1:0];
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Write channel capture; address and data may arrive in either order
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_idx_q  <= 10'h000;
         wdata_q   <= 8'h00;
         wlane_q   <= 1'b0;
      end
      else
      begin
         if (AWVALID_I && awready_q)
         begin
            aw_have_q <= 1'b1;
            awready_q <= 1'b0;
            aw_idx_q  <= AWADDR_I[11:2];
         end
         if (WVALID_I && wready_q)
         begin
            w_have_q <= 1'b1;
            wready_q <= 1'b0;
            wdata_q  <= WDATA_I[7:0];
            wlane_q  <= WSTRB_I[0];
         end
         if (bvalid_q && BREADY_I)
         begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   // Write response; unmapped indices answer SLVERR and change nothing
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= `WIT_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         case (aw_idx_q)
            `WIT_IDX_TIMER_CONTROL_STATUS, `WIT_IDX_COUNT_WR, `WIT_IDX_RCC_WR,
            `WIT_IDX_IRQ_STAT, `WIT_IDX_IRQ_MASK:
               bresp_q <= `WIT_RESP_OKAY;
            default:
               bresp_q <= `WIT_RESP_SLVERR;
         endcase
      end
      else if (BREADY_I)
         bvalid_q <= 1'b0;
   end

   // Read channel; one read outstanding, data sampled at the address edge
   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `WIT_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= `WIT_RESP_OKAY;
         case (ar_idx)
            `WIT_IDX_TIMER_CONTROL_STATUS:
               rdata_q <= {24'h00_0000, timer_control_status_q[5:3], 2'h0, timer_control_status_q[2:0]} | 32'(`WIT_TIMER_CONTROL_STATUS_RSVD);
            `WIT_IDX_COUNT_RD:
               rdata_q <= {24'h00_0000, count_q};
            `WIT_IDX_RCC_RD:
               rdata_q <= {24'h00_0000, rcc_q, 6'h00} | 32'(`WIT_RCC_RSVD); // RQ7
            `WIT_IDX_IRQ_STAT:
               rdata_q <= {30'h0000_0000, irq_stat_q};
            `WIT_IDX_IRQ_MASK:
               rdata_q <= {30'h0000_0000, irq_mask_q};
            default:
            begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= `WIT_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_q && RREADY_I)
      begin
         rvalid_q  <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Port drive, all from flip-flops
   assign AWREADY_O = awready_q;
   assign WREADY_O  = wready_q;
   assign BVALID_O  = bvalid_q;
   assign BRESP_O   = bresp_q;
   assign ARREADY_O = arready_q;
   assign RVALID_O  = rvalid_q;
   assign RDATA_O   = rdata_q;
   assign RRESP_O   = rresp_q;
   assign IRQ_O     = irq_q;

endmodule

// ===== sim/wit_timer_props.sv
`timescale 1ns/10ps
`include "wit_consts.svh"

module wit_timer_props
(
   // Clock and reset
   input wire logic        MCLK_I,
   input wire logic        RESETN_I,
   // Write channels
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic        BVALID_O,
   input wire logic        BREADY_I,
   input wire logic [1:0]  BRESP_O,
   // Read channels
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic        RVALID_O,
   input wire logic        RREADY_I,
   input wire logic [31:0] RDATA_O,
   input wire logic [1:0]  RRESP_O,
   // Reset outputs
   input wire logic        WDT_RESET_O,
   input wire logic        RESET_PIN_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESETN_I);

   // Pulse split in halves to keep the repetition count small
   sequence half_pulse_s;
      WDT_RESET_O [*8];
   endsequence
   sequence full_pulse_s;
      half_pulse_s ##1 half_pulse_s ##1 !WDT_RESET_O;
   endsequence
   sequence both_taken_s;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence

   wdt_pulse_a : assert property ($rose(WDT_RESET_O) |-> full_pulse_s)
      else $error("internal reset pulse is not sixteen cycles");
   pin_low_a : assert property (RESET_PIN_O == 1'b0)
      else $error("reset pin driven high");
   b_latency_a : assert property (both_taken_s |=> !BVALID_O ##1 BVALID_O)
      else $error("write response timing wrong");
   b_hold_a : assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
      else $error("write response dropped early");
   w_busy_a : assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
      else $error("write accepted while response pending");
   r_latency_a : assert property (ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O)
      else $error("read data not one cycle after address");
   r_hold_a : assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data dropped early");
   err_data_a : assert property (RVALID_O && RRESP_O == `WIT_RESP_SLVERR |-> RDATA_O == 32'h0)
      else $error("refused read returns data");
   byte_reg_a : assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0)
      else $error("register read above bit seven");
endmodule

bind wit_timer wit_timer_props u_wit_timer_props
(
   .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
   .WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
   .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
   .RREADY_I(RREADY_I), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .WDT_RESET_O(WDT_RESET_O),
   .RESET_PIN_O(RESET_PIN_O)
);

// ===== sim/test_wit_timer.sv
`timescale 1ns/10ps
`include "wit_consts.svh"

module test_wit_timer;
   // Byte addresses are four times the register index
   localparam logic [11:0] A_TC = {`WIT_IDX_TIMER_CONTROL_STATUS, 2'b00};
   localparam logic [11:0] A_CR = {`WIT_IDX_COUNT_RD, 2'b00};
   localparam logic [11:0] A_CW = {`WIT_IDX_COUNT_WR, 2'b00};
   localparam logic [11:0] A_RR = {`WIT_IDX_RCC_RD, 2'b00};
   localparam logic [11:0] A_RW = {`WIT_IDX_RCC_WR, 2'b00};
   localparam logic [11:0] A_ST = {`WIT_IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] A_MK = {`WIT_IDX_IRQ_MASK, 2'b00};
   localparam logic [1:0]  OK   = `WIT_RESP_OKAY;
   localparam logic [1:0]  ERR  = `WIT_RESP_SLVERR;

   logic        MCLK_I, RESETN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
   logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
   logic        IRQ_O, WDT_RESET_O, RESET_PIN_O, RESET_PIN_OE_O;
   logic [11:0] AWADDR_I, ARADDR_I;
   logic [31:0] WDATA_I, RDATA_O;
   logic [3:0]  WSTRB_I;
   logic [1:0]  BRESP_O, RRESP_O;
   int          n_errors = 0;
   int          checks_done = 0;

   wit_timer u_wit_timer
   (
      .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O),
      .AWADDR_I(AWADDR_I), .AWPROT_I(3'h0), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
      .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
      .BRESP_O(BRESP_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .ARADDR_I(ARADDR_I),
      .ARPROT_I(3'h0), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O),
      .RRESP_O(RRESP_O), .IRQ_O(IRQ_O), .WDT_RESET_O(WDT_RESET_O), .RESET_PIN_O(RESET_PIN_O),
      .RESET_PIN_OE_O(RESET_PIN_OE_O)
   );

   // 20 MHz clock
   always #25 MCLK_I = ~MCLK_I;

   task automatic report_and_stop();
      if (n_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Address and data offered together, each released at its own handshake
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      AWADDR_I <= a;
      WDATA_I <= d;
      AWVALID_I <= 1'b1;
      WVALID_I <= 1'b1;
      BREADY_I <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge MCLK_I);
         if (!aw_ok && AWREADY_O === 1'b1)
         begin
            aw_ok = 1'b1;
            AWVALID_I <= 1'b0;
         end
         if (!w_ok && WREADY_O === 1'b1)
         begin
            w_ok = 1'b1;
            WVALID_I <= 1'b0;
         end
      end
      do @(posedge MCLK_I); while (BVALID_O !== 1'b1);
      BREADY_I <= 1'b0;
      check("write resp", 32'(BRESP_O), 32'(r));
      // Spare edge so no request line is driven twice in one step
      @(posedge MCLK_I);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] r);
      ARADDR_I <= a;
      ARVALID_I <= 1'b1;
      RREADY_I <= 1'b1;
      do @(posedge MCLK_I); while (ARREADY_O !== 1'b1);
      ARVALID_I <= 1'b0;
      do @(posedge MCLK_I); while (RVALID_O !== 1'b1);
      RREADY_I <= 1'b0;
      check($sformatf("read %h", a), RDATA_O, x);
      check("read resp", 32'(RRESP_O), 32'(r));
      @(posedge MCLK_I);
   endtask

   // Watchdog overflow from FD at the fastest tap; slow tap first so the load is kept
   task automatic trip(input logic [7:0] oe);
      wr(A_RW, {24'h0, oe}, OK);
      wr(A_TC, 32'h0000_0067, OK);
      wr(A_CW, 32'h0000_00FD, OK);
      wr(A_TC, 32'h0000_0060, OK);
      do @(posedge MCLK_I); while (WDT_RESET_O !== 1'b1);
      repeat (2) @(posedge MCLK_I);
      check("pin oe", 32'(RESET_PIN_OE_O), 32'(oe[6]));
      do @(posedge MCLK_I); while (WDT_RESET_O !== 1'b0);
   endtask

   // Watchdog on a hung test
   initial
   begin
      repeat (20000) @(posedge MCLK_I);
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      {MCLK_I, RESETN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 7'h00;
      {AWADDR_I, ARADDR_I, WDATA_I} = 56'h0;
      WSTRB_I = 4'hF;
      repeat (10) @(posedge MCLK_I);
      RESETN_I <= 1'b1;
      @(posedge MCLK_I);
      // Reset values, refused accesses and the ignored low strobe
      rd(A_TC, 32'h0000_0018, OK);
      rd(A_RR, 32'h0000_003F, OK);
      rd(A_ST, 32'h0000_0000, OK);
      rd(12'h000, 32'h0000_0000, ERR);
      wr(12'h000, 32'h0000_0001, ERR);
      wr(A_RR, 32'h0000_0040, ERR);
      wr(A_CR, 32'h0000_0011, ERR);
      WSTRB_I <= 4'hE;
      wr(A_MK, 32'h0000_0001, OK);
      WSTRB_I <= 4'hF;
      rd(A_MK, 32'h0000_0000, OK);
      wr(A_CW, 32'h0000_0055, OK);
      rd(A_CR, 32'h0000_0000, OK);
      // Interval overflow, then clear only after a read that sees it set
      wr(A_TC, 32'h0000_0027, OK);
      wr(A_CW, 32'h0000_00FD, OK);
      wr(A_TC, 32'h0000_0020, OK);
      repeat (30) @(posedge MCLK_I);
      rd(A_TC, 32'h0000_00B8, OK);
      wr(A_TC, 32'h0000_0080, OK);
      wr(A_TC, 32'h0000_0000, OK);
      rd(A_TC, 32'h0000_0098, OK);
      wr(A_TC, 32'h0000_0000, OK);
      rd(A_TC, 32'h0000_0018, OK);
      rd(A_CR, 32'h0000_0000, OK);
      rd(A_ST, 32'h0000_0001, OK);
      wr(A_MK, 32'h0000_0001, OK);
      repeat (2) @(posedge MCLK_I);
      check("irq on", 32'(IRQ_O), 32'h1);
      wr(A_MK, 32'h0000_0000, OK);
      repeat (2) @(posedge MCLK_I);
      check("irq masked", 32'(IRQ_O), 32'h0);
      wr(A_ST, 32'h0000_0001, OK);
      rd(A_ST, 32'h0000_0000, OK);
      // Watchdog overflow with pin drive, then the clear-only cause flag
      trip(8'h40);
      rd(A_TC, 32'h0000_0018, OK);
      rd(A_RR, 32'h0000_00FF, OK);
      rd(A_ST, 32'h0000_0002, OK);
      wr(A_RW, 32'h0000_00C0, OK);
      wr(A_RW, 32'h0000_0040, OK);
      rd(A_RR, 32'h0000_00FF, OK);
      wr(A_RW, 32'h0000_0040, OK);
      rd(A_RR, 32'h0000_007F, OK);
      wr(A_ST, 32'h0000_0002, OK);
      // Cause flag set again, then cleared by the external pin
      trip(8'h00);
      rd(A_RR, 32'h0000_00BF, OK);
      RESETN_I <= 1'b0;
      repeat (2) @(posedge MCLK_I);
      RESETN_I <= 1'b1;
      @(posedge MCLK_I);
      rd(A_RR, 32'h0000_003F, OK);
      report_and_stop();
   end
endmodule
